// ===== logic_cell.v
// configurable logic cell with table generators, output selects and storage, on AXI4-Lite
`timescale 1ns/100ps
`default_nettype none
`include "logic_cell_map.vh"

module logic_cell (
    input wire sys_clk,
    input wire reset_n,
    input wire [7:0] awaddr,
    input wire awvalid,
    output wire awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    input wire [7:0] araddr,
    input wire arvalid,
    output wire arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    input wire [3:0] lutOneInputs,
    input wire [3:0] lutTwoInputs,
    input wire combinerExtAltA,
    input wire combinerExtFixed,
    input wire combinerExtAltB,
    input wire directData,
    input wire cellClock,
    output wire cellOutX,
    output wire cellOutY,
    output wire storedX,
    output wire storedY
);

    // configuration memory
    reg [15:0] lutOne;
    reg [15:0] lutTwo;
    reg [7:0] lutComb;
    reg [9:0] ctrl;

    // write channel holding state
    reg awHeld;
    reg wHeld;
    reg [7:0] awAddrHeld;
    reg [31:0] wDataHeld;
    reg [3:0] wStrbHeld;

    // cell signals
    wire fResult;
    wire gResult;
    wire combA;
    wire combB;
    wire combResult;
    wire [1:0] genPair;
    wire clockRise;
    reg cellClockPrev;
    reg [1:0] storedQ;
    wire doWrite;
    wire [7:0] wrAddr;
    wire [7:0] rdAddr;

    // merged write words, one per register
    wire [31:0] mergedOne;
    wire [31:0] mergedTwo;
    wire [31:0] mergedComb;
    wire [31:0] mergedCtrl;

    // named control fields
    wire combAFromExt;
    wire combBFromExt;
    wire xFromComb;
    wire yFromComb;

    // write decode and live status
    wire wrHitLutOne;
    wire wrHitLutTwo;
    wire wrHitLutComb;
    wire wrHitCtrl;
    wire wrHitStatus;
    wire [31:0] statusWord;

    // ------------------------------------------------------------------------
    // byte lane merge
    // ------------------------------------------------------------------------

    // lanes without a strobe keep their old contents
    function [31:0] mergeLanes;
        input [31:0] oldValue;
        input [31:0] newValue;
        input [3:0] strobe;
        integer k;
        begin
            mergeLanes = oldValue;
            for (k = 0; k < 4; k = k + 1) begin
                if (strobe[k]) begin
                    mergeLanes[k*8 +: 8] = newValue[k*8 +: 8];
                end
            end
        end
    endfunction

    // one merged word per register, cut to the register's width at the update
    assign mergedOne = mergeLanes({16'h0000, lutOne}, wDataHeld, wStrbHeld);
    assign mergedTwo = mergeLanes({16'h0000, lutTwo}, wDataHeld, wStrbHeld);
    assign mergedComb = mergeLanes({24'h000000, lutComb}, wDataHeld, wStrbHeld);
    assign mergedCtrl = mergeLanes({22'h000000, ctrl}, wDataHeld, wStrbHeld);

    // ------------------------------------------------------------------------
    // write channels
    // ------------------------------------------------------------------------

    // address and data are taken in either order, refused while a response waits
    assign awready = ~awHeld & ~bvalid;
    assign wready = ~wHeld & ~bvalid;
    assign doWrite = awHeld & wHeld;
    assign wrAddr = {awAddrHeld[7:2], 2'b00};

    // held address decoded once, so the update chain reads plainly
    assign wrHitLutOne = (wrAddr == `ADDR_LUT_ONE);
    assign wrHitLutTwo = (wrAddr == `ADDR_LUT_TWO);
    assign wrHitLutComb = (wrAddr == `ADDR_LUT_COMB);
    assign wrHitCtrl = (wrAddr == `ADDR_CTRL);
    assign wrHitStatus = (wrAddr == `ADDR_STATUS);

    // capture address and data, then update one cycle after both are held
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddrHeld <= 8'h00;
            wDataHeld <= 32'h00000000;
            wStrbHeld <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            lutOne <= `RST_LUT_ONE;
            lutTwo <= `RST_LUT_TWO;
            lutComb <= `RST_LUT_COMB;
            ctrl <= `RST_CTRL;
        end else begin
            if (awvalid && awready) begin
                awHeld <= 1'b1;
                awAddrHeld <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld <= 1'b1;
                wDataHeld <= wdata;
                wStrbHeld <= wstrb;
            end
            if (doWrite) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                bvalid <= 1'b1;
                bresp <= `RESP_OKAY;
                if (wrHitLutOne) begin
                    lutOne <= mergedOne[15:0];
                end else if (wrHitLutTwo) begin
                    lutTwo <= mergedTwo[15:0];
                end else if (wrHitLutComb) begin
                    lutComb <= mergedComb[7:0];
                end else if (wrHitCtrl) begin
                    ctrl <= mergedCtrl[9:0];
                end else if (wrHitStatus) begin
                    bresp <= `RESP_OKAY; // read-only, write ignored
                end else begin
                    bresp <= `RESP_SLVERR;
                end
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------------------

    // one read at a time, answered the cycle after the address is taken
    assign arready = ~rvalid;
    assign rdAddr = {araddr[7:2], 2'b00};

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= `RESP_OKAY;
            if (rdAddr == `ADDR_LUT_ONE) begin
                rdata <= {16'h0000, lutOne};
            end else if (rdAddr == `ADDR_LUT_TWO) begin
                rdata <= {16'h0000, lutTwo};
            end else if (rdAddr == `ADDR_LUT_COMB) begin
                rdata <= {24'h000000, lutComb};
            end else if (rdAddr == `ADDR_CTRL) begin
                rdata <= {22'h000000, ctrl};
            end else if (rdAddr == `ADDR_STATUS) begin
                // live cell state, sampled when the address is taken
                rdata <= statusWord;
            end else begin
                rdata <= 32'h00000000;
                rresp <= `RESP_SLVERR;
            end
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------------------

    // named fields keep the select logic free of bit positions
    assign combAFromExt = ctrl[`CTRL_COMB_A_EXT];
    assign combBFromExt = ctrl[`CTRL_COMB_B_EXT];
    assign xFromComb = ctrl[`CTRL_X_FROM_COMB];
    assign yFromComb = ctrl[`CTRL_Y_FROM_COMB];

    // ------------------------------------------------------------------------
    // generators and output selects
    // ------------------------------------------------------------------------

    // table lookup keeps delay the same whatever function is loaded
    assign fResult = lutOne[lutOneInputs];
    assign gResult = lutTwo[lutTwoInputs];

    // two combiner legs are selectable, the middle one is fixed outside
    assign combA = combAFromExt ? combinerExtAltA : fResult;
    assign combB = combBFromExt ? combinerExtAltB : gResult;
    assign combResult = lutComb[{combB, combinerExtFixed, combA}];

    // only two unstored results can leave, a third must go to storage
    assign cellOutX = xFromComb ? combResult : fResult;
    assign cellOutY = yFromComb ? combResult : gResult;

    // ------------------------------------------------------------------------
    // storage elements
    // ------------------------------------------------------------------------

    // cell clock comes from logic on sys_clk, so no synchroniser is needed
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cellClockPrev <= 1'b0;
        end else begin
            cellClockPrev <= cellClock;
        end
    end

    assign clockRise = cellClock & ~cellClockPrev;
    assign genPair = {gResult, fResult};

    // one element per output; the sources are free of the output selects
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : store
            wire [1:0] srcSel;
            wire latchMode;
            reg nextData;

            assign srcSel = ctrl[`CTRL_STORE_SRC + 2*i +: 2];
            assign latchMode = ctrl[`CTRL_STORE_LATCH + i] & `CELL_EXTENDED;

            // direct input may feed one while the combiner feeds the other
            always @* begin
                nextData = genPair[i];
                if (srcSel == `SRC_COMB) begin
                    nextData = combResult;
                end else if (srcSel == `SRC_DIRECT) begin
                    nextData = directData;
                end
            end

            // latch follows with one cycle of sampling delay
            always @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    storedQ[i] <= 1'b0;
                end else if (latchMode) begin
                    if (cellClock) begin
                        storedQ[i] <= nextData;
                    end
                end else if (clockRise) begin
                    storedQ[i] <= nextData;
                end
            end
        end
    endgenerate

    // stored outputs stand apart from the combinational ones
    assign storedX = storedQ[0];
    assign storedY = storedQ[1];

    // ------------------------------------------------------------------------
    // status word
    // ------------------------------------------------------------------------

    // bit 7 and everything above bit 8 read as zero
    assign statusWord[0] = fResult;
    assign statusWord[1] = gResult;
    assign statusWord[2] = combResult;
    assign statusWord[3] = cellOutX;
    assign statusWord[4] = cellOutY;
    assign statusWord[5] = storedX;
    assign statusWord[6] = storedY;
    assign statusWord[7] = 1'b0;
    assign statusWord[8] = `CELL_EXTENDED;
    assign statusWord[31:9] = 23'h000000;

endmodule
`default_nettype wire

// ===== logic_cell_map.vh
// register map, field positions and reset values of the configurable logic cell
// ----------------------------------------------------------------------------
// How it works
// - each of the two four-input generators looks its result up in a 16-entry table set by software.
// - the combiner looks any function of its three inputs up in an 8-entry table.
// - two combiner inputs each take a generator result or an outside input, the middle one is always outside.
// - the primary output shows the first generator or the combiner, as configured.
// - the secondary output shows the second generator or the combiner, as configured.
// - two storage elements can hold generator results and may also be used apart from the generators.
// - each storage element is a flip-flop, or a latch when the extended variant is present.
// - the direct data input may feed either storage element while the combiner feeds the other.
// - the two combinational outputs are separate from the two stored outputs.
// - only two unstored generator results leave the cell, so a third function must be stored.
// - the cell has thirteen inputs and four outputs toward the interconnect.
// ----------------------------------------------------------------------------
`ifndef LOGIC_CELL_MAP_VH
`define LOGIC_CELL_MAP_VH

// byte addresses of the registers
`define ADDR_LUT_ONE 8'h00
`define ADDR_LUT_TWO 8'h04
`define ADDR_LUT_COMB 8'h08
`define ADDR_CTRL 8'h0C
`define ADDR_STATUS 8'h10

// reset values
`define RST_LUT_ONE 16'h0000
`define RST_LUT_TWO 16'h0000
`define RST_LUT_COMB 8'h00
`define RST_CTRL 10'h000

// control field positions
`define CTRL_COMB_A_EXT 0
`define CTRL_COMB_B_EXT 1
`define CTRL_X_FROM_COMB 2
`define CTRL_Y_FROM_COMB 3
`define CTRL_STORE_SRC 4
`define CTRL_STORE_LATCH 8

// storage source codes
`define SRC_GEN 2'h0
`define SRC_COMB 2'h1
`define SRC_DIRECT 2'h2

// latch mode present in this build
`define CELL_EXTENDED 1'b1

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== logic_cell_checker_asserts.sv
// bus handshake and storage hold checker for the logic cell
`timescale 1ns/100ps
`default_nettype none
module logic_cell_checker (
    input wire sys_clk,
    input wire reset_n,
    input wire awvalid,
    input wire awready,
    input wire wvalid,
    input wire wready,
    input wire [1:0] bresp,
    input wire bvalid,
    input wire bready,
    input wire arvalid,
    input wire arready,
    input wire rvalid,
    input wire rready,
    input wire cellClock,
    input wire storedX,
    input wire storedY
);
    // ----------------------------------------
    // properties, all in the system clock domain
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence wrTaken; awvalid && awready && wvalid && wready; endsequence
    sequence respSeen; ##[1:2] bvalid; endsequence
    write_resp_a: assert property (wrTaken |-> respSeen) else $error("write unanswered");
    read_resp_a: assert property (arvalid && arready |=> rvalid) else $error("read unanswered");
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    rvalid_hold_a: assert property (rvalid && !rready |=> rvalid) else $error("read data dropped");
    rvalid_drop_a: assert property (rvalid && rready |=> !rvalid) else $error("read repeated");
    read_block_a: assert property (rvalid |-> !arready) else $error("read taken while busy");
    write_block_a: assert property (bvalid |-> !awready && !wready) else $error("write overlap");
    // a low cell clock never moves either element, flop or latch alike
    store_hold_a: assert property (!cellClock |=> $stable({storedX, storedY}))
        else $error("storage moved with cell clock low");
endmodule
bind logic_cell logic_cell_checker u_checker (.sys_clk(sys_clk), .reset_n(reset_n),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
    .rready(rready), .cellClock(cellClock), .storedX(storedX), .storedY(storedY));
`default_nettype wire

// ===== cell_neighbour.sv
// far-side interconnect model: neighbour nets feeding the cell inputs
`timescale 1ns/100ps
`default_nettype none
module cell_neighbour (
    input wire logic sys_clk,
    input wire logic [12:0] netPattern,
    output logic [3:0] lutOneInputs,
    output logic [3:0] lutTwoInputs,
    output logic combinerExtAltA,
    output logic combinerExtFixed,
    output logic combinerExtAltB,
    output logic directData,
    output logic cellClock
);
    // --------------------------------
    // nets launched from neighbour flops
    // --------------------------------
    // registered so every net, cell clock too, moves just after an edge
    always @(posedge sys_clk) begin
        {cellClock, directData, combinerExtAltB, combinerExtFixed, combinerExtAltA,
            lutTwoInputs, lutOneInputs} <= netPattern;
    end
endmodule
`default_nettype wire

// ===== logic_cell_tb.sv
// self-checking bench for the logic cell: bus access, table outputs and storage
`timescale 1ns/100ps
`default_nettype none
`include "logic_cell_map.vh"
`define CHK(a, e) begin checkCount++; if ((a) !== (e)) begin errTotal++; \
    $display("wrong value at %0t: %h expected %h", $time, a, e); end end
module logic_cell_tb;
    logic sys_clk, reset_n, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
    logic awready, wready, arready, cellOutX, cellOutY, storedX, storedY, directData;
    logic combinerExtAltA, combinerExtFixed, combinerExtAltB, cellClock;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, got;
    logic [3:0] wstrb, lutOneInputs, lutTwoInputs;
    logic [1:0] bresp, rresp;
    logic [12:0] netPattern;
    int errTotal = 0, checkCount = 0, cycles = 0;
    localparam logic [15:0] TAB_F = 16'hA5C3, TAB_G = 16'h3C96;
    localparam logic [7:0] TAB_C = 8'hE8;
    logic_cell DUT (.sys_clk, .reset_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .lutOneInputs, .lutTwoInputs, .combinerExtAltA, .combinerExtFixed,
        .combinerExtAltB, .directData, .cellClock, .cellOutX, .cellOutY, .storedX, .storedY);
    cell_neighbour farSide (.sys_clk, .netPattern, .lutOneInputs, .lutTwoInputs,
        .combinerExtAltA, .combinerExtFixed, .combinerExtAltB, .directData, .cellClock);
    // ----------------------------
    // clock, watchdog, bus tasks
    // ----------------------------
    initial begin
        sys_clk = 1'h0;
        forever #4 sys_clk = ~sys_clk;
    end
    // the whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errTotal++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (errTotal == 0 && checkCount > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
        `CHK(bresp, e)
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] e);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        got = rdata;
        rready <= 1'h0;
        `CHK(rresp, e)
        @(posedge sys_clk);
    endtask
    // three edges: neighbour launch, storage capture, one spare before the checks
    task automatic drive(input logic [12:0] p);
        netPattern <= p;
        repeat (3) @(posedge sys_clk);
    endtask
    // main sequence
    initial begin
        {reset_n, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wdata, netPattern} = 61'h0;
        wstrb = 4'hF;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'h1;
        @(posedge sys_clk);
        rd(`ADDR_CTRL, `RESP_OKAY);
        `CHK(got, 32'h0)
        rd(`ADDR_STATUS, `RESP_OKAY);
        `CHK(got, 32'h100)
        rd(8'h40, `RESP_SLVERR);
        `CHK(got, 32'h0)
        wr(8'h40, 32'h5, `RESP_SLVERR);
        wr(`ADDR_LUT_ONE, TAB_F, `RESP_OKAY);
        wr(`ADDR_LUT_TWO, TAB_G, `RESP_OKAY);
        wr(`ADDR_LUT_COMB, TAB_C, `RESP_OKAY);
        for (int i = 0; i < 16; i++) begin
            drive({5'h0, ~i[3:0], i[3:0]});
            `CHK(cellOutX, TAB_F[i])
            `CHK(cellOutY, TAB_G[15 - i])
        end
        wr(`ADDR_CTRL, 32'hF, `RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            drive({2'h0, i[2:0], 8'h0});
            `CHK(cellOutX, TAB_C[i])
            `CHK(cellOutY, TAB_C[i])
        end
        // outside legs set opposite to the generators so a wrong select shows
        wr(`ADDR_CTRL, 32'hC, `RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            drive({2'h0, ~i[1], 1'h1, ~i[0], 3'h0, i[1], 1'h0, ~i[0], 2'h0});
            `CHK(cellOutX, TAB_C[{i[1], 1'h1, i[0]}])
            `CHK(cellOutY, TAB_C[{i[1], 1'h1, i[0]}])
        end
        for (int k = 0; k < 2; k++) begin
            wr(`ADDR_CTRL, k ? 32'h9F : 32'h6F, `RESP_OKAY);
            drive(13'h0800);
            drive(13'h1800);
            `CHK({storedX, storedY}, k ? 2'h1 : 2'h2)
            drive(13'h1000);
            `CHK({storedX, storedY}, k ? 2'h1 : 2'h2)
        end
        wr(`ADDR_CTRL, 32'h34F, `RESP_OKAY);
        drive(13'h1000);
        `CHK(storedX, 1'h1)
        drive(13'h1002);
        `CHK(storedX, 1'h0)
        drive(13'h0000);
        `CHK(storedX, 1'h0)
        rd(`ADDR_LUT_ONE, `RESP_OKAY);
        `CHK(got, {16'h0, TAB_F})
        // only the low byte lane is written, the rest must keep its table bits
        wstrb <= 4'h1;
        wr(`ADDR_LUT_TWO, 32'hFFFF, `RESP_OKAY);
        rd(`ADDR_LUT_TWO, `RESP_OKAY);
        `CHK(got, {16'h0, TAB_G[15:8], 8'hFF})
        end_of_test();
    end
endmodule
`default_nettype wire
